// *** mcs_status_check.sv ***
// Microword status check logic with APB diagnostic registers
// What this block does
// - Check type decoded from select code subfields
// - Field overlap sets bit 0 above 32
// - Packed sign: nibble zero and negative tests
// - Data-size check echoes context size signals
// - Char sign: 00 minus, 01 plus/space, 11
// - Unsigned range: 00, 01 zero, 10, 11
// - Signed abs range on write-bus byte
// - Rotation from select code always performed
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`default_nettype none
module mcs_status_check
  import mcs_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic ALU_EXT_SEL_IN,
  input wire logic [2:0] ALU_SHIFT_SEL_IN,
  input wire logic [1:0] ALU_CARRY_IN_SEL_IN,
  input wire logic [3:0] SHIFTER_BUS_LOW_IN,
  input wire logic [7:0] WRITE_BUS_LOW_IN,
  input wire logic [5:0] FIELD_POSITION_IN,
  input wire logic [5:0] FIELD_SIZE_IN,
  input wire logic [1:0] CONTEXT_SIZE_IN,
  output logic [1:0] CHECK_STATUS_PAIR_OUT,
  output logic [5:0] ROT_FUNC_OUT,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT
);

  // ***************************************************************
  // State
  // ***************************************************************
  typedef struct packed {
    logic [1:0] status;
    logic [5:0] rot;
    mcs_check_t ctype;
    logic ovr_en;
    logic [1:0] ovr_val;
    logic [31:0] prdata;
  } mcs_state_t;

  localparam mcs_state_t MCS_STATE_RST = '{
    status: MCS_ST_00,
    rot: MCS_CODE_ZERO,
    ctype: MCS_CT_NONE,
    ovr_en: MCS_OVR_OFF,
    ovr_val: MCS_ST_00,
    prdata: MCS_DATA_ZERO
  };

  mcs_state_t st_r;
  mcs_state_t st_nxt;
  logic [MCS_CODE_W-1:0] check_select_code;
  mcs_check_t check_type;
  logic [6:0] field_sum;
  logic [1:0] byte_result;
  logic [1:0] check_result;
  logic addr_ok;
  logic apb_setup;
  logic apb_write;

  assign check_select_code = {ALU_EXT_SEL_IN, ALU_SHIFT_SEL_IN, ALU_CARRY_IN_SEL_IN};

  // ***************************************************************
  // Check type decode
  // ***************************************************************
  always_comb begin
    check_type = MCS_CT_NONE;
    if (check_select_code[5] == MCS_ABS_MSB && check_select_code[4] == MCS_ABS_MSB) begin
      check_type = MCS_CT_ABS;
    end else begin
      case (check_select_code[5:2])
        MCS_GRP_DSIZE_A, MCS_GRP_DSIZE_B: begin
          check_type = MCS_CT_DSIZE;
        end
        MCS_GRP_PACKED_A, MCS_GRP_PACKED_B: begin
          check_type = MCS_CT_PACKED;
        end
        MCS_GRP_CHAR_A, MCS_GRP_CHAR_B: begin
          check_type = MCS_CT_CHAR;
        end
        MCS_GRP_FIELD: begin
          if (check_select_code != MCS_CODE_FIELD_EXCL) begin
            check_type = MCS_CT_FIELD;
          end
        end
        MCS_GRP_URANGE: begin
          check_type = MCS_CT_URANGE;
        end
        default: begin
          check_type = MCS_CT_NONE;
        end
      endcase
    end
  end

  mcs_byte_classify u_byte_classify (
    .check_type_in(check_type),
    .byte_in(WRITE_BUS_LOW_IN),
    .result_out(byte_result)
  );

  // ***************************************************************
  // Status pair selection
  // ***************************************************************
  always_comb begin
    // Field size beyond 1..32 gives an undefined result
    field_sum = {2'h0, FIELD_POSITION_IN[4:0]} + {1'h0, FIELD_SIZE_IN};
    check_result = MCS_ST_00;
    case (check_type)
      MCS_CT_FIELD: begin
        check_result[1] = (FIELD_SIZE_IN == MCS_SIZE_ZERO);
        check_result[0] = (field_sum > MCS_FIELD_LIMIT);
      end
      MCS_CT_PACKED: begin
        check_result[1] = (SHIFTER_BUS_LOW_IN != MCS_NIB_ZERO);
        check_result[0] = (SHIFTER_BUS_LOW_IN != MCS_NEG_SIGN_A) &&
                          (SHIFTER_BUS_LOW_IN != MCS_NEG_SIGN_B);
      end
      MCS_CT_DSIZE: begin
        check_result = CONTEXT_SIZE_IN;
      end
      MCS_CT_CHAR, MCS_CT_URANGE, MCS_CT_ABS: begin
        check_result = byte_result;
      end
      default: begin
        check_result = MCS_ST_00;
      end
    endcase
  end

  // ***************************************************************
  // Next state and APB slave
  // ***************************************************************
  always_comb begin
    addr_ok = (PADDR_IN == MCS_REG_CTRL) || (PADDR_IN == MCS_REG_STATUS);
    apb_setup = PSEL_IN && !PENABLE_IN;
    apb_write = PSEL_IN && PENABLE_IN && PWRITE_IN && (PADDR_IN == MCS_REG_CTRL);
    st_nxt = st_r;
    st_nxt.status = st_r.ovr_en ? st_r.ovr_val : check_result;
    st_nxt.rot = check_select_code;
    st_nxt.ctype = check_type;
    if (apb_write) begin
      st_nxt.ovr_en = PWDATA_IN[MCS_CTRL_OVR_EN];
      st_nxt.ovr_val = PWDATA_IN[MCS_CTRL_OVR_HI:MCS_CTRL_OVR_LO];
    end
    if (apb_setup) begin
      st_nxt.prdata = MCS_DATA_ZERO;
      if (!PWRITE_IN && PADDR_IN == MCS_REG_CTRL) begin
        st_nxt.prdata[MCS_CTRL_OVR_EN] = st_r.ovr_en;
        st_nxt.prdata[MCS_CTRL_OVR_HI:MCS_CTRL_OVR_LO] = st_r.ovr_val;
      end else if (!PWRITE_IN && PADDR_IN == MCS_REG_STATUS) begin
        st_nxt.prdata[MCS_STAT_PAIR_HI:MCS_STAT_PAIR_LO] = st_r.status;
        st_nxt.prdata[MCS_STAT_TYPE_HI:MCS_STAT_TYPE_LO] = st_r.ctype;
        st_nxt.prdata[MCS_STAT_CODE_HI:MCS_STAT_CODE_LO] = st_r.rot;
      end
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      st_r <= MCS_STATE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign CHECK_STATUS_PAIR_OUT = st_r.status;
  assign ROT_FUNC_OUT = st_r.rot;
  assign PRDATA_OUT = st_r.prdata;
  assign PREADY_OUT = PSEL_IN && PENABLE_IN;
  assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !addr_ok;

  // ***************************************************************
  // Checks
  // ***************************************************************
  default clocking mcs_cb @(posedge CLK_IN);
  endclocking
  default disable iff (RST_IN);

  chk_type_bcd_group: assert property (
    (check_select_code[5:2] == MCS_GRP_PACKED_A || check_select_code[5:2] == MCS_GRP_PACKED_B)
    |=> st_r.ctype == MCS_CT_PACKED
  ) else $error("Packed sign group not decoded");

  chk_field_cross: assert property (
    (check_type == MCS_CT_FIELD && !st_r.ovr_en && !apb_write)
    |=> CHECK_STATUS_PAIR_OUT[0] == ($past(field_sum) > MCS_FIELD_LIMIT)
  ) else $error("Field overlap bit wrong");

  chk_bcd_sign: assert property (
    (check_type == MCS_CT_PACKED && SHIFTER_BUS_LOW_IN == MCS_NEG_SIGN_B && !st_r.ovr_en
     && !apb_write) |=> CHECK_STATUS_PAIR_OUT == MCS_ST_10
  ) else $error("Packed negative sign not flagged");

  chk_dsize_echo: assert property (
    (check_type == MCS_CT_DSIZE && !st_r.ovr_en && !apb_write)
    |=> CHECK_STATUS_PAIR_OUT == $past(CONTEXT_SIZE_IN)
  ) else $error("Context size not echoed");

  chk_ascii_no_mchk: assert property (
    (check_type == MCS_CT_CHAR && !st_r.ovr_en && !apb_write)
    |=> CHECK_STATUS_PAIR_OUT != MCS_ST_10
  ) else $error("Char sign check gave machine-check code");

  chk_range_top: assert property (
    (check_type == MCS_CT_URANGE && WRITE_BUS_LOW_IN == MCS_URANGE_TOP && !st_r.ovr_en
     && !apb_write) |=> CHECK_STATUS_PAIR_OUT == MCS_ST_10
  ) else $error("Unsigned range top value wrong");

  chk_abs_neg_edge: assert property (
    (check_type == MCS_CT_ABS && $signed(WRITE_BUS_LOW_IN) == MCS_ABS_NEG_MIN
     && !st_r.ovr_en && !apb_write) |=> CHECK_STATUS_PAIR_OUT == MCS_ST_00
  ) else $error("Abs check at lower edge wrong");

  chk_rot_follow: assert property (
    1'b1 |=> ROT_FUNC_OUT == $past(check_select_code)
  ) else $error("Rotation code not passed to shifter");

  chk_status_next: assert property (
    (!st_r.ovr_en && !apb_write) |=> CHECK_STATUS_PAIR_OUT == $past(check_result)
  ) else $error("Status pair not ready next cycle");

endmodule
`default_nettype wire

// *** mcs_pkg.sv ***
// Constants, types and register map of the microword status check block
`default_nettype none
package mcs_pkg;

  // ***************************************************************
  // Check types and select-code groups
  // ***************************************************************
  typedef enum logic [2:0] {
    MCS_CT_NONE,
    MCS_CT_DSIZE,
    MCS_CT_PACKED,
    MCS_CT_CHAR,
    MCS_CT_FIELD,
    MCS_CT_URANGE,
    MCS_CT_ABS
  } mcs_check_t;

  localparam int unsigned MCS_CODE_W = 6;
  // Select code = {alu_extension_sel, alu_shift_sel, alu_carry_in_sel}
  localparam logic [3:0] MCS_GRP_DSIZE_A = 4'h2;
  localparam logic [3:0] MCS_GRP_DSIZE_B = 4'h3;
  localparam logic [3:0] MCS_GRP_PACKED_A = 4'h4;
  localparam logic [3:0] MCS_GRP_CHAR_A = 4'h5;
  localparam logic [3:0] MCS_GRP_PACKED_B = 4'h6;
  localparam logic [3:0] MCS_GRP_CHAR_B = 4'h7;
  localparam logic [3:0] MCS_GRP_FIELD = 4'h9;
  localparam logic [3:0] MCS_GRP_URANGE = 4'hB;
  localparam logic [5:0] MCS_CODE_FIELD_EXCL = 6'h27;
  localparam logic MCS_ABS_MSB = 1'h1;

  // ***************************************************************
  // Test constants
  // ***************************************************************
  localparam logic [6:0] MCS_FIELD_LIMIT = 7'h20;
  localparam logic [5:0] MCS_SIZE_ZERO = 6'h00;
  localparam logic [5:0] MCS_CODE_ZERO = 6'h00;
  localparam logic MCS_OVR_OFF = 1'h0;
  localparam logic [3:0] MCS_NIB_ZERO = 4'h0;
  localparam logic [3:0] MCS_NEG_SIGN_A = 4'hB;
  localparam logic [3:0] MCS_NEG_SIGN_B = 4'hD;
  localparam logic [7:0] MCS_CHAR_MINUS = 8'h2D;
  localparam logic [7:0] MCS_CHAR_SPACE = 8'h20;
  localparam logic [7:0] MCS_CHAR_PLUS = 8'h2B;
  localparam logic [7:0] MCS_BYTE_ZERO = 8'h00;
  localparam logic [7:0] MCS_URANGE_TOP = 8'h20;
  localparam logic signed [7:0] MCS_ABS_POS_MAX = 8'sh1F;
  localparam logic signed [7:0] MCS_ABS_NEG_MIN = -8'sh1F;
  localparam logic signed [7:0] MCS_SBYTE_ZERO = 8'sh00;

  localparam logic [1:0] MCS_ST_00 = 2'h0;
  localparam logic [1:0] MCS_ST_01 = 2'h1;
  localparam logic [1:0] MCS_ST_10 = 2'h2;
  localparam logic [1:0] MCS_ST_11 = 2'h3;

  // ***************************************************************
  // Register map
  // ***************************************************************
  localparam logic [7:0] MCS_REG_CTRL = 8'h00;
  localparam logic [7:0] MCS_REG_STATUS = 8'h04;
  localparam int unsigned MCS_CTRL_OVR_EN = 0;
  localparam int unsigned MCS_CTRL_OVR_LO = 1;
  localparam int unsigned MCS_CTRL_OVR_HI = 2;
  localparam int unsigned MCS_STAT_PAIR_LO = 0;
  localparam int unsigned MCS_STAT_PAIR_HI = 1;
  localparam int unsigned MCS_STAT_TYPE_LO = 4;
  localparam int unsigned MCS_STAT_TYPE_HI = 6;
  localparam int unsigned MCS_STAT_CODE_LO = 8;
  localparam int unsigned MCS_STAT_CODE_HI = 13;
  localparam logic [31:0] MCS_DATA_ZERO = 32'h0000_0000;

endpackage
`default_nettype wire

// *** mcs_byte_classify.sv ***
// Write-bus byte classifier for the char sign, unsigned range and abs checks
`default_nettype none
module mcs_byte_classify
  import mcs_pkg::*;
(
  input wire mcs_check_t check_type_in,
  input wire logic [7:0] byte_in,
  output logic [1:0] result_out
);

  logic signed [7:0] sbyte;

  always_comb begin
    sbyte = $signed(byte_in);
    result_out = MCS_ST_00;
    case (check_type_in)
      MCS_CT_CHAR: begin
        // Code 10 is never produced; it is the machine-check code
        if (byte_in == MCS_CHAR_MINUS) begin
          result_out = MCS_ST_00;
        end else if (byte_in == MCS_CHAR_SPACE || byte_in == MCS_CHAR_PLUS) begin
          result_out = MCS_ST_01;
        end else begin
          result_out = MCS_ST_11;
        end
      end
      MCS_CT_URANGE: begin
        if (byte_in == MCS_BYTE_ZERO) begin
          result_out = MCS_ST_01;
        end else if (byte_in < MCS_URANGE_TOP) begin
          result_out = MCS_ST_00;
        end else if (byte_in == MCS_URANGE_TOP) begin
          result_out = MCS_ST_10;
        end else begin
          result_out = MCS_ST_11;
        end
      end
      MCS_CT_ABS: begin
        if (sbyte < MCS_ABS_NEG_MIN) begin
          result_out = MCS_ST_01;
        end else if (sbyte < MCS_SBYTE_ZERO) begin
          result_out = MCS_ST_00;
        end else if (sbyte <= MCS_ABS_POS_MAX) begin
          result_out = MCS_ST_10;
        end else begin
          result_out = MCS_ST_11;
        end
      end
      default: begin
        result_out = MCS_ST_00;
      end
    endcase
  end

endmodule
`default_nettype wire

// *** mcs_useq_model.sv ***
// Microsequencer model: context size source and branch sampler
`default_nettype none
module mcs_useq_model (
  input wire logic clk_in,
  input wire logic [1:0] ctx_set_in,
  input wire logic [1:0] status_in,
  output logic [1:0] ctx_size_out,
  output logic [1:0] branch_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ***********************
  // Context and branch
  // ***********************
  always_ff @(posedge clk_in) begin
    ctx_size_out <= ctx_set_in;
    branch_out <= status_in;
  end
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Self-checking bench for the microword status check block
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; \
  $display("[ERR] %0t got %0h exp %0h", $time, a, b); end end
module tb_top
  import mcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ***********************
  // Signals and instances
  // ***********************
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [5:0] code = 6'h00;
  logic [3:0] sb = 4'h0;
  logic [7:0] wb = 8'h00;
  logic [5:0] pos = 6'h00;
  logic [5:0] sz = 6'h01;
  logic [1:0] ctx_set = 2'h0;
  logic [1:0] ctx, st, br;
  logic [5:0] rot;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er;
  int errors = 0;
  int checked = 0;
  int cycles = 0;
  always #10 clk = ~clk;
  mcs_status_check dut_u (.CLK_IN(clk), .RST_IN(rst), .ALU_EXT_SEL_IN(code[5]),
    .ALU_SHIFT_SEL_IN(code[4:2]), .ALU_CARRY_IN_SEL_IN(code[1:0]),
    .SHIFTER_BUS_LOW_IN(sb), .WRITE_BUS_LOW_IN(wb), .FIELD_POSITION_IN(pos),
    .FIELD_SIZE_IN(sz), .CONTEXT_SIZE_IN(ctx), .CHECK_STATUS_PAIR_OUT(st),
    .ROT_FUNC_OUT(rot), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr));
  mcs_useq_model useq_u (.clk_in(clk), .ctx_set_in(ctx_set), .status_in(st),
    .ctx_size_out(ctx), .branch_out(br));
  // ***********************
  // Shared tasks
  // ***********************
  task automatic run(input logic [5:0] c, input logic [3:0] s, input logic [7:0] w,
    input logic [5:0] p, input logic [5:0] z, input logic [1:0] e);
    @(posedge clk);
    code <= c; sb <= s; wb <= w; pos <= p; sz <= z;
    @(posedge clk);
    #1;
    `CHK(st, e)
    `CHK(rot, c)
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; pen <= 1'b0;
  endtask
  task automatic tally_and_finish();
    if (errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ***********************
  // Scenarios
  // ***********************
  task automatic t_dsize();
    for (int i = 0; i < 8; i++) begin
      ctx_set = i[1:0];
      run(6'h08 + i[5:0], 4'h5, 8'h41, 6'h00, 6'h01, i[1:0]);
    end
  endtask
  task automatic t_packed();
    run(6'h10, 4'h0, 8'h00, 6'h00, 6'h01, 2'h1);
    run(6'h13, 4'hB, 8'h00, 6'h00, 6'h01, 2'h2);
    run(6'h18, 4'hD, 8'h00, 6'h00, 6'h01, 2'h2);
    run(6'h1B, 4'hC, 8'h00, 6'h00, 6'h01, 2'h3);
  endtask
  task automatic t_char();
    run(6'h14, 4'h0, 8'h2D, 6'h00, 6'h01, 2'h0);
    run(6'h17, 4'h0, 8'h20, 6'h00, 6'h01, 2'h1);
    run(6'h1C, 4'h0, 8'h2B, 6'h00, 6'h01, 2'h1);
    run(6'h1F, 4'h0, 8'h2C, 6'h00, 6'h01, 2'h3);
    @(posedge clk);
    #1;
    `CHK(br, 2'h3)
  endtask
  task automatic t_field();
    // Sizes kept within 1 to 32
    run(6'h24, 4'h0, 8'h00, 6'h1F, 6'h01, 2'h0);
    run(6'h25, 4'h0, 8'h00, 6'h1F, 6'h02, 2'h1);
    run(6'h26, 4'h0, 8'h00, 6'h20, 6'h20, 2'h0);
    run(6'h24, 4'h0, 8'h00, 6'h01, 6'h20, 2'h1);
  endtask
  task automatic t_urange();
    run(6'h2C, 4'h0, 8'h00, 6'h00, 6'h01, 2'h1);
    run(6'h2D, 4'h0, 8'h01, 6'h00, 6'h01, 2'h0);
    run(6'h2E, 4'h0, 8'h1F, 6'h00, 6'h01, 2'h0);
    run(6'h2F, 4'h0, 8'h20, 6'h00, 6'h01, 2'h2);
    run(6'h2C, 4'h0, 8'h21, 6'h00, 6'h01, 2'h3);
  endtask
  task automatic t_abs();
    run(6'h30, 4'h0, 8'hFF, 6'h00, 6'h01, 2'h0);
    run(6'h35, 4'h0, 8'hE1, 6'h00, 6'h01, 2'h0);
    run(6'h3B, 4'h0, 8'hE0, 6'h00, 6'h01, 2'h1);
    run(6'h3D, 4'h0, 8'h00, 6'h00, 6'h01, 2'h2);
    run(6'h3E, 4'h0, 8'h1F, 6'h00, 6'h01, 2'h2);
    run(6'h3F, 4'h0, 8'h20, 6'h00, 6'h01, 2'h3);
  endtask
  task automatic t_unlisted();
    run(6'h07, 4'h5, 8'h41, 6'h1F, 6'h20, 2'h0);
    run(6'h23, 4'h5, 8'h41, 6'h1F, 6'h20, 2'h0);
    run(6'h27, 4'h5, 8'h41, 6'h1F, 6'h20, 2'h0);
  endtask
  task automatic t_regs();
    apb(1'b1, MCS_REG_CTRL, 32'h0000_0007);
    run(6'h00, 4'h0, 8'h00, 6'h00, 6'h01, 2'h3);
    apb(1'b0, MCS_REG_CTRL, 32'h0);
    `CHK({er, rd}, {1'b0, 32'h0000_0007})
    apb(1'b0, 8'h08, 32'h0);
    `CHK({er, rd}, {1'b1, 32'h0})
    apb(1'b1, MCS_REG_CTRL, 32'h0);
    run(6'h2C, 4'h0, 8'h20, 6'h00, 6'h01, 2'h2);
    apb(1'b0, MCS_REG_STATUS, 32'h0);
    `CHK(rd, 32'h0000_2C52)
  endtask
  task automatic t_reset();
    // Mid-run reset clears outputs and the override
    apb(1'b1, MCS_REG_CTRL, 32'h0000_0005);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    `CHK({st, rot, prdata}, {2'h0, 6'h00, 32'h0})
    @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, MCS_REG_CTRL, 32'h0);
    `CHK({er, rd}, {1'b0, 32'h0})
    run(6'h2C, 4'h0, 8'h00, 6'h00, 6'h01, 2'h1);
  endtask
  // ***********************
  // Main sequence
  // ***********************
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_dsize();
    t_packed();
    t_char();
    t_field();
    t_urange();
    t_abs();
    t_unlisted();
    t_regs();
    t_reset();
    tally_and_finish();
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors++;
      tally_and_finish();
    end
  end
endmodule
`default_nettype wire
